//--- pkg/limiter_ctrl_pkg.sv
// constants shared by the battery-tracking limiter control block
package limiter_ctrl_pkg;
   // ****************************************************
   // register offsets and reset values
   // ****************************************************
   localparam logic [7:0] LEFT_THR_SLOPE_ADDR   = 8'h0f;
   localparam logic [7:0] LEFT_KNEE_ADDR        = 8'h10;
   localparam logic [7:0] RIGHT_RATES_MODE_ADDR = 8'h11;
   localparam logic [7:0] LEFT_THR_SLOPE_RST    = 8'h51;
   localparam logic [7:0] LEFT_KNEE_RST         = 8'h22;
   localparam logic [7:0] RIGHT_RATES_MODE_RST  = 8'ha8;
   // writable bit masks; reserved bits stay zero
   localparam logic [7:0] LEFT_THR_SLOPE_MASK   = 8'hfb;
   localparam logic [7:0] LEFT_KNEE_MASK        = 8'hff;
   localparam logic [7:0] RIGHT_RATES_MODE_MASK = 8'hff;
   // ****************************************************
   // field positions
   // ****************************************************
   localparam int THR_LSB      = 3;
   localparam int THR_MSB      = 7;
   localparam int SLOPE_LSB    = 0;
   localparam int SLOPE_MSB    = 1;
   localparam int RELEASE_LSB  = 6;
   localparam int RELEASE_MSB  = 7;
   localparam int ATTACK_LSB   = 4;
   localparam int ATTACK_MSB   = 5;
   localparam int JOIN_BIT     = 3;
   localparam int TRACK_BIT    = 2;
   localparam int MODE_LSB     = 0;
   localparam int MODE_MSB     = 1;
   // ****************************************************
   // limiter modes and threshold range
   // ****************************************************
   localparam logic [1:0] MODE_OFF        = 2'h0;
   localparam logic [1:0] MODE_ON         = 2'h1;
   localparam logic [1:0] MODE_MUTE_LOW   = 2'h2;
   localparam logic [1:0] MODE_LIMIT_LOW  = 2'h3;
   localparam logic [4:0] THR_CODE_MAX    = 5'h1f;
   // threshold in millivolts: code 0 and the fine-step band
   localparam logic [13:0] THR_MV_TOP     = 14'h3e80;  // 16000
   localparam logic [13:0] THR_MV_STEP    = 14'h01f4;  // 500
   localparam logic [13:0] THR_MV_FINE    = 14'h00fa;  // 250
   localparam logic [4:0]  FINE_FIRST     = 5'h0e;     // code 14
   localparam logic [4:0]  FINE_LAST      = 5'h13;     // code 19
endpackage

//--- design/limiter_channel.sv
// one channel: effective threshold, tracking ramp and mode decode
`timescale 1ns/1ps
module limiter_channel
   import limiter_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // settings
   input  wire logic [4:0]  thr_code,
   input  wire logic [1:0]  slope,
   input  wire logic        track,
   input  wire logic [7:0]  knee,
   input  wire logic [1:0]  mode,
   // sensed battery, same scale as knee
   input  wire logic [7:0]  battery_level,
   // results
   output logic      [4:0]  eff_code,
   output logic      [13:0] eff_mv,
   output logic             active,
   output logic             mute
);
   // ****************************************************
   // combinational decode
   // ****************************************************
   logic        below;
   logic [7:0]  deficit;
   logic [9:0]  drop;
   logic [10:0] ramp_sum;
   logic [4:0]  code_d;
   logic [13:0] mv_d;

   assign below    = battery_level < knee;
   assign deficit  = below ? knee - battery_level : 8'h00;
   // ratio slope+1 : 1 of threshold drop to battery drop
   assign drop     = 10'(deficit) * (10'(slope) + 10'h001);
   assign ramp_sum = 11'(thr_code) + 11'(drop);
   // ramp only below the knee, saturating at the lowest threshold
   assign code_d   = (track && below) ? ((ramp_sum > 11'(THR_CODE_MAX)) ? THR_CODE_MAX : ramp_sum[4:0])
                                      : thr_code;

   // 16 V at code 0 down to 2 V at code 31, with a 250 mV band
   function automatic logic [13:0] code_to_mv(input logic [4:0] c);
      logic [13:0] cc;
      logic [13:0] fine_top;
      cc = 14'(c);
      // the fine band hangs off the last coarse code, not off its own first code
      fine_top = THR_MV_TOP - (14'(FINE_FIRST) - 14'h0001) * THR_MV_STEP;
      if (c < FINE_FIRST)
         code_to_mv = THR_MV_TOP - cc * THR_MV_STEP;
      else if (c <= FINE_LAST)
         code_to_mv = fine_top - (cc - 14'(FINE_FIRST) + 14'h0001) * THR_MV_FINE;
      else
         code_to_mv = fine_top - (14'(FINE_LAST) - 14'(FINE_FIRST) + 14'h0001) * THR_MV_FINE
                      - (cc - 14'(FINE_LAST)) * THR_MV_STEP;
   endfunction
   assign mv_d = code_to_mv(code_d);

   // ****************************************************
   // registered results
   // ****************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         eff_code <= 5'h00;
         eff_mv   <= THR_MV_TOP;
         active   <= 1'b0;
         mute     <= 1'b0;
      end else if (ce) begin
         eff_code <= code_d;
         eff_mv   <= mv_d;
         active   <= (mode == MODE_ON) || (mode == MODE_LIMIT_LOW && below);
         mute     <= (mode == MODE_MUTE_LOW) && below;
      end
   end
endmodule // limiter_channel

//--- design/battery_tracking_limiter_ctrl.sv
// limiter control registers, channel link and per-channel limiter settings
`timescale 1ns/1ps
module battery_tracking_limiter_ctrl
   import limiter_ctrl_pkg::*;
(
   // clock, reset, enable
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // register access port
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // controls held in neighbouring registers
   input  wire logic [1:0]  left_release_speed,
   input  wire logic [1:0]  left_attack_speed,
   input  wire logic        left_track,
   input  wire logic [1:0]  left_limiter_select,
   input  wire logic [4:0]  right_threshold_code,
   input  wire logic [1:0]  right_slope,
   input  wire logic [7:0]  right_battery_knee,
   // sensed battery level from the on-chip converter
   input  wire logic [7:0]  battery_level,
   // left channel settings
   output logic      [4:0]  left_eff_code,
   output logic      [13:0] left_eff_mv,
   output logic             left_active,
   output logic             left_mute,
   output logic      [1:0]  left_release_out,
   output logic      [1:0]  left_attack_out,
   // right channel settings
   output logic      [4:0]  right_eff_code,
   output logic      [13:0] right_eff_mv,
   output logic             right_active,
   output logic             right_mute,
   output logic      [1:0]  right_release_out,
   output logic      [1:0]  right_attack_out
);
   import limiter_ctrl_pkg::*;

   // ****************************************************
   // register file
   // ****************************************************
   logic [7:0] thr_slope_q;
   logic [7:0] knee_q;
   logic [7:0] rates_mode_q;
   logic [7:0] rdata_d;
   logic       wr_thr;
   logic       wr_knee;
   logic       wr_rates;

   assign wr_thr   = ce && reg_wr && reg_addr == LEFT_THR_SLOPE_ADDR;
   assign wr_knee  = ce && reg_wr && reg_addr == LEFT_KNEE_ADDR;
   assign wr_rates = ce && reg_wr && reg_addr == RIGHT_RATES_MODE_ADDR;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         thr_slope_q  <= LEFT_THR_SLOPE_RST;
         knee_q       <= LEFT_KNEE_RST;
         rates_mode_q <= RIGHT_RATES_MODE_RST;
      end else begin
         // masking keeps reserved bits at zero
         if (wr_thr)
            thr_slope_q <= reg_wdata & LEFT_THR_SLOPE_MASK;
         if (wr_knee)
            knee_q <= reg_wdata & LEFT_KNEE_MASK;
         if (wr_rates)
            rates_mode_q <= reg_wdata & RIGHT_RATES_MODE_MASK;
      end
   end

   // unmapped offsets read zero
   assign rdata_d = (reg_addr == LEFT_THR_SLOPE_ADDR)   ? thr_slope_q :
                    (reg_addr == LEFT_KNEE_ADDR)        ? knee_q :
                    (reg_addr == RIGHT_RATES_MODE_ADDR) ? rates_mode_q : 8'h00;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else if (ce && reg_rd)
         reg_rdata <= rdata_d;
   end

   // ****************************************************
   // channel link selection
   // ****************************************************
   logic       join_sel;
   logic [4:0] r_thr;
   logic [1:0] r_slope;
   logic       r_track;
   logic [7:0] r_knee;
   logic [1:0] r_mode;
   logic [1:0] r_release;
   logic [1:0] r_attack;

   // joined channels follow the left controls only
   assign join_sel  = rates_mode_q[JOIN_BIT];
   assign r_thr     = join_sel ? thr_slope_q[THR_MSB:THR_LSB] : right_threshold_code;
   assign r_slope   = join_sel ? thr_slope_q[SLOPE_MSB:SLOPE_LSB] : right_slope;
   assign r_track   = join_sel ? left_track : rates_mode_q[TRACK_BIT];
   assign r_knee    = join_sel ? knee_q : right_battery_knee;
   assign r_mode    = join_sel ? left_limiter_select : rates_mode_q[MODE_MSB:MODE_LSB];
   assign r_release = join_sel ? left_release_speed : rates_mode_q[RELEASE_MSB:RELEASE_LSB];
   assign r_attack  = join_sel ? left_attack_speed : rates_mode_q[ATTACK_MSB:ATTACK_LSB];

   // rate codes go to the gain stepper, aligned with the channel results
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         left_release_out  <= 2'h2;
         left_attack_out   <= 2'h2;
         right_release_out <= 2'h2;
         right_attack_out  <= 2'h2;
      end else if (ce) begin
         left_release_out  <= left_release_speed;
         left_attack_out   <= left_attack_speed;
         right_release_out <= r_release;
         right_attack_out  <= r_attack;
      end
   end

   // ****************************************************
   // channel instances
   // ****************************************************
   limiter_channel u_left (
      .core_clk      (core_clk),
      .rst_n         (rst_n),
      .ce            (ce),
      .thr_code      (thr_slope_q[THR_MSB:THR_LSB]),
      .slope         (thr_slope_q[SLOPE_MSB:SLOPE_LSB]),
      .track         (left_track),
      .knee          (knee_q),
      .mode          (left_limiter_select),
      .battery_level (battery_level),
      .eff_code      (left_eff_code),
      .eff_mv        (left_eff_mv),
      .active        (left_active),
      .mute          (left_mute)
   );

   limiter_channel u_right (
      .core_clk      (core_clk),
      .rst_n         (rst_n),
      .ce            (ce),
      .thr_code      (r_thr),
      .slope         (r_slope),
      .track         (r_track),
      .knee          (r_knee),
      .mode          (r_mode),
      .battery_level (battery_level),
      .eff_code      (right_eff_code),
      .eff_mv        (right_eff_mv),
      .active        (right_active),
      .mute          (right_mute)
   );

   // ****************************************************
   // assertions
   // ****************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // sampled rst_n keeps the edge that releases reset out of the antecedent
   a_fixed_thresh_hold: assert property (rst_n && ce && !left_track
                                         |=> left_eff_code == $past(thr_slope_q[THR_MSB:THR_LSB]))
      else $error("fixed threshold not held");
   a_code31_two_volt: assert property (ce && !left_track && thr_slope_q[THR_MSB:THR_LSB] == THR_CODE_MAX
                                       |=> left_eff_mv == 14'h07d0)
      else $error("code 31 not 2 V");
   a_track_lowers: assert property (ce && left_track && battery_level < knee_q
                                    |=> left_eff_code >= $past(thr_slope_q[THR_MSB:THR_LSB]))
      else $error("tracking raised threshold");
   a_slope_four_one: assert property (ce && left_track && thr_slope_q[SLOPE_MSB:SLOPE_LSB] == 2'h3
                                      && 9'(battery_level) + 9'h001 == 9'(knee_q)
                                      && thr_slope_q[THR_MSB:THR_LSB] < 5'h1b
                                      |=> left_eff_code == $past(thr_slope_q[THR_MSB:THR_LSB]) + 5'h04)
      else $error("4:1 slope wrong");
   a_knee_readback: assert property (wr_knee ##1 (ce && reg_rd && reg_addr == LEFT_KNEE_ADDR && !reg_wr)
                                     |=> reg_rdata == $past(reg_wdata, 2))
      else $error("knee not stored");
   a_release_route: assert property (rst_n && ce |=> right_release_out == $past(r_release)
                                     && right_attack_out == $past(r_attack))
      else $error("rate code not routed");
   a_join_follows_left: assert property (ce && join_sel && !left_track
                                         |=> right_eff_code == left_eff_code && right_mute == left_mute)
      else $error("joined right differs from left");
   a_mute_below_knee: assert property (ce && left_limiter_select == MODE_MUTE_LOW && battery_level < knee_q
                                       |=> left_mute && !left_active)
      else $error("mute mode not applied");
   a_reserved_zero: assert property (ce && reg_rd && reg_addr == LEFT_THR_SLOPE_ADDR |=> reg_rdata[2] == 1'b0)
      else $error("reserved bit not zero");

   c_unjoin: cover property (wr_rates && !reg_wdata[JOIN_BIT]);
   c_muted: cover property (left_mute);
   c_ramp_floor: cover property (left_track && left_eff_code == THR_CODE_MAX);
endmodule // battery_tracking_limiter_ctrl

//--- tb/battery_tracking_limiter_ctrl_test.sv
// self-checking testbench for the limiter control registers and channel settings
`timescale 1ns/1ps
module battery_tracking_limiter_ctrl_test;
   import limiter_ctrl_pkg::*;
   logic        core_clk, rst_n, ce, reg_wr, reg_rd, left_track;
   logic [1:0]  left_release_speed, left_attack_speed, left_limiter_select, right_slope;
   logic [4:0]  right_threshold_code, left_eff_code, right_eff_code;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, right_battery_knee, battery_level, rb;
   logic [13:0] left_eff_mv, right_eff_mv;
   logic        left_active, left_mute, right_active, right_mute;
   logic [1:0]  left_release_out, left_attack_out, right_release_out, right_attack_out;
   int          miscompares, checks_done;

   battery_tracking_limiter_ctrl battery_tracking_limiter_ctrl_i (
      .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .left_release_speed(left_release_speed), .left_attack_speed(left_attack_speed),
      .left_track(left_track), .left_limiter_select(left_limiter_select),
      .right_threshold_code(right_threshold_code), .right_slope(right_slope),
      .right_battery_knee(right_battery_knee), .battery_level(battery_level),
      .left_eff_code(left_eff_code), .left_eff_mv(left_eff_mv), .left_active(left_active),
      .left_mute(left_mute), .left_release_out(left_release_out), .left_attack_out(left_attack_out),
      .right_eff_code(right_eff_code), .right_eff_mv(right_eff_mv), .right_active(right_active),
      .right_mute(right_mute), .right_release_out(right_release_out),
      .right_attack_out(right_attack_out)
   );

   // ****************************************************
   // shared helpers
   // ****************************************************
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 rb = reg_rdata;
   endtask

   // outputs follow a write one edge after the edge that takes it
   task automatic settle;
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   function automatic logic [13:0] mv_of(input int c);
      if (c <= 13) return 14'(16000 - 500 * c);
      else if (c <= 19) return 14'(9500 - 250 * (c - 13));
      else return 14'(8000 - 500 * (c - 19));
   endfunction

   // ****************************************************
   // scenarios
   // ****************************************************
   task automatic t_reset;
      rd(8'h0f); check("thr_slope", 16'h0051, {8'h00, rb});
      rd(8'h10); check("knee", 16'h0022, {8'h00, rb});
      rd(8'h11); check("rates_mode", 16'h00a8, {8'h00, rb});
      check("left_code", 16'd10, {11'h000, left_eff_code});
      check("right_release", 16'd2, {14'h0000, right_release_out});
   endtask

   task automatic t_reserved;
      wr(8'h0f, 8'hff);
      rd(8'h0f); check("reserved bit", 16'h00fb, {8'h00, rb});
      wr(8'h20, 8'h5a);
      rd(8'h20); check("unmapped", 16'h0000, {8'h00, rb});
      @(posedge core_clk);
      ce <= 1'b0;
      wr(8'h10, 8'h77);
      @(posedge core_clk);
      ce <= 1'b1;
      rd(8'h10); check("frozen knee", 16'h0022, {8'h00, rb});
      @(posedge core_clk);
      reg_addr  <= 8'h10;
      reg_wdata <= 8'h5c;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge core_clk);
      reg_rd    <= 1'b0;
      #1 rb = reg_rdata;
      check("back to back knee", 16'h005c, {8'h00, rb});
      wr(8'h10, 8'h22);
   endtask

   task automatic t_table;
      for (int c = 0; c < 32; c++) begin
         wr(8'h0f, {c[4:0], 3'b001});
         settle();
         check("left_code", 16'(c), {11'h000, left_eff_code});
         check("left_mv", {2'b00, mv_of(c)}, {2'b00, left_eff_mv});
      end
   endtask

   task automatic t_track;
      @(posedge core_clk);
      left_track    <= 1'b1;
      battery_level <= 8'd30;
      for (int s = 0; s < 4; s++) begin
         wr(8'h0f, {5'd10, 1'b0, s[1:0]});
         settle();
         check("ramp", 16'(10 + 4 * (s + 1)), {11'h000, left_eff_code});
      end
      wr(8'h0f, {5'd28, 3'b011});
      settle();
      check("ramp clamp", 16'd31, {11'h000, left_eff_code});
      @(posedge core_clk);
      battery_level <= 8'd40;
      settle();
      check("above knee", 16'd28, {11'h000, left_eff_code});
      wr(8'h10, 8'd41);
      settle();
      check("moved knee", 16'd31, {11'h000, left_eff_code});
      wr(8'h0f, {5'd20, 3'b011});
      settle();
      check("one step 4:1", 16'd24, {11'h000, left_eff_code});
      wr(8'h10, 8'h22);
      @(posedge core_clk);
      left_track <= 1'b0;
   endtask

   task automatic t_modes;
      logic below;
      for (int m = 0; m < 4; m++) begin
         for (int b = 30; b <= 40; b += 10) begin
            below = (b < 34);
            @(posedge core_clk);
            left_limiter_select <= m[1:0];
            battery_level       <= b[7:0];
            settle();
            check("mute", {15'h0000, (m == 2) && below}, {15'h0000, left_mute});
            check("active", {15'h0000, (m == 1) || (m == 3 && below)}, {15'h0000, left_active});
         end
      end
   endtask

   task automatic t_join;
      @(posedge core_clk);
      left_release_speed  <= 2'd1;
      left_attack_speed   <= 2'd3;
      left_limiter_select <= 2'd1;
      wr(8'h0f, {5'd5, 3'b001});
      settle();
      check("joined code", 16'd5, {11'h000, right_eff_code});
      check("joined release", 16'd1, {14'h0000, right_release_out});
      check("joined attack", 16'd3, {14'h0000, right_attack_out});
      check("joined active", 16'd1, {15'h0000, right_active});
      check("joined mv", 16'd13500, {2'b00, right_eff_mv});
      check("left release", 16'd1, {14'h0000, left_release_out});
      check("left attack", 16'd3, {14'h0000, left_attack_out});
      for (int r = 0; r < 4; r++) begin
         wr(8'h11, {r[1:0], ~r[1:0], 4'b0000});
         settle();
         check("release", 16'(r), {14'h0000, right_release_out});
         check("attack", {14'h0000, ~r[1:0]}, {14'h0000, right_attack_out});
         check("own code", 16'd7, {11'h000, right_eff_code});
         check("own mode off", 16'd0, {15'h0000, right_active});
      end
      @(posedge core_clk);
      battery_level <= 8'd30;
      wr(8'h11, 8'ha6);
      settle();
      check("own ramp", 16'd15, {11'h000, right_eff_code});
      check("own mv", 16'd9000, {2'b00, right_eff_mv});
      check("own mute", 16'd1, {15'h0000, right_mute});
      check("own mute inactive", 16'd0, {15'h0000, right_active});
      wr(8'h11, 8'ha8);
   endtask

   task automatic results;
      if (miscompares == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   initial begin
      repeat (5000) @(posedge core_clk);
      miscompares++;
      results();
   end

   initial begin
      {rst_n, reg_wr, reg_rd, left_track, reg_addr, reg_wdata} = '0;
      ce                   = 1'b1;
      left_release_speed   = 2'd2;
      left_attack_speed    = 2'd2;
      left_limiter_select  = 2'd0;
      right_threshold_code = 5'd7;
      right_slope          = 2'd1;
      right_battery_knee   = 8'h22;
      battery_level        = 8'd40;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_reserved();
      t_table();
      t_track();
      t_modes();
      t_join();
      results();
   end
endmodule // battery_tracking_limiter_ctrl_test
